// ---- ptim_pkg.sv ----
package ptim_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int IND_DELAY_MS = 24;
   localparam int IND_DELAY_CYC = (IND_DELAY_MS * (CLK_HZ / 1000));
   // Signature pulse period in cycles and the on-times per duty (per mille of period)
   localparam int PULSE_PERIOD_CYC = 1000;
   localparam int DUTY_26_PM = 260;
   localparam int DUTY_12P5_PM = 125;
   localparam int DUTY_8P1_PM = 81;
   localparam int DUTY_5P4_PM = 54;
   localparam int CNT_W = 24;
   localparam int PCNT_W = 10;

   // ************************************************************
   // Encodings
   // ************************************************************
   typedef enum logic [1:0] {
      PTIM_DUTY_SHORT = 2'h0,
      PTIM_DUTY_RES = 2'h1,
      PTIM_DUTY_OPEN = 2'h2
   } ptim_duty_e;

   typedef enum logic [1:0] {
      PTIM_ST_OFF = 2'h0,
      PTIM_ST_INRUSH = 2'h1,
      PTIM_ST_SETTLE = 2'h3,
      PTIM_ST_ON = 2'h2
   } ptim_state_e;

   localparam logic [2:0] CLASS_EVENT_1 = 3'h1;
   localparam logic [2:0] CLASS_EVENT_4 = 3'h4;
   localparam logic [2:0] CLASS_EVENT_5 = 3'h5;

   // Flag level 1 = released (high), 0 = pulled low
   typedef struct packed {
      logic power_level_high_flag;
      logic power_level_low_flag;
      logic high_type_equipment_flag;
   } ptim_flags_s;

   localparam ptim_flags_s FLAGS_RELEASED = 3'h7;

   typedef struct packed {
      logic high_type_equipment;
      logic [2:0] class_events;
   } ptim_class_s;

endpackage : ptim_pkg

// ---- ptim_pulse_gen.sv ----
`timescale 1ns/10ps
module ptim_pulse_gen #(
   parameter int PERIOD = ptim_pkg::PULSE_PERIOD_CYC
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic [ptim_pkg::PCNT_W-1:0] on_cycles_i,
   output logic pulse_o
);
   typedef struct packed {
      logic [ptim_pkg::PCNT_W-1:0] cnt;
      logic pulse;
   } ptim_pg_s;

   ptim_pg_s st_ff;
   ptim_pg_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (!enable_i) begin
         nxt_st.cnt = '0;
         nxt_st.pulse = 1'b0;
      end else begin
         if (st_ff.cnt == ptim_pkg::PCNT_W'(PERIOD - 1)) begin
            nxt_st.cnt = '0;
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
         nxt_st.pulse = (nxt_st.cnt < on_cycles_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pulse_o = st_ff.pulse;
endmodule : ptim_pulse_gen

// ---- ptim_indicator.sv ----
`timescale 1ns/10ps
module ptim_indicator #(
   parameter int IND_DELAY = ptim_pkg::IND_DELAY_CYC,
   parameter int PERIOD = ptim_pkg::PULSE_PERIOD_CYC
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic above_mark_reset_i,
   input wire logic above_undervoltage_lockout_i,
   input wire logic above_32v_i,
   input wire logic thermal_shutdown_i,
   input wire logic inrush_done_i,
   input wire logic class_valid_i,
   input wire ptim_pkg::ptim_class_s class_i,
   input wire ptim_pkg::ptim_duty_e pulse_duty_select_i,
   input wire logic load_return_low_i,
   output logic power_good_out_o,
   output logic power_good_out_oe_o,
   output ptim_pkg::ptim_flags_s flags_o,
   output ptim_pkg::ptim_flags_s flags_oe_o,
   output logic signature_pulse_out_o
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_ff;
   logic [NSYNC-1:0] s2_ff;
   logic [NSYNC-1:0] s3_ff;
   logic [NSYNC-1:0] filt_ff;

   assign raw_in = {above_mark_reset_i, above_undervoltage_lockout_i, above_32v_i,
                    thermal_shutdown_i, inrush_done_i, load_return_low_i};

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         filt_ff <= '0;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < NSYNC; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               filt_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   logic mark_ok;
   logic uv_ok;
   logic v32_ok;
   logic tsd;
   logic inr_done;
   logic ld_low;
   assign {mark_ok, uv_ok, v32_ok, tsd, inr_done, ld_low} = filt_ff;

   // ************************************************************
   // Encoding
   // ************************************************************
   function automatic ptim_pkg::ptim_flags_s encode_flags(input ptim_pkg::ptim_class_s c);
      ptim_pkg::ptim_flags_s f;
      f = ptim_pkg::FLAGS_RELEASED;
      f.high_type_equipment_flag = !c.high_type_equipment;
      if (c.class_events <= ptim_pkg::CLASS_EVENT_1) begin
         f.power_level_high_flag = 1'b1;
         f.power_level_low_flag = 1'b1;
      end else if (c.class_events < ptim_pkg::CLASS_EVENT_4 || !c.high_type_equipment) begin
         f.power_level_high_flag = 1'b1;
         f.power_level_low_flag = 1'b0;
      end else if (c.class_events == ptim_pkg::CLASS_EVENT_4) begin
         f.power_level_high_flag = 1'b0;
         f.power_level_low_flag = 1'b1;
      end else begin
         f.power_level_high_flag = 1'b0;
         f.power_level_low_flag = 1'b0;
      end
      return f;
   endfunction : encode_flags

   function automatic logic [ptim_pkg::PCNT_W-1:0] duty_on(input logic ht,
                                                          input ptim_pkg::ptim_duty_e d);
      int pm;
      pm = ptim_pkg::DUTY_26_PM;
      if (ht) begin
         unique case (d)
            ptim_pkg::PTIM_DUTY_SHORT: pm = ptim_pkg::DUTY_12P5_PM;
            ptim_pkg::PTIM_DUTY_RES: pm = ptim_pkg::DUTY_8P1_PM;
            default: pm = ptim_pkg::DUTY_5P4_PM;
         endcase
      end
      return ptim_pkg::PCNT_W'((pm * PERIOD) / ptim_pkg::PULSE_PERIOD_CYC);
   endfunction : duty_on

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      ptim_pkg::ptim_state_e fsm;
      logic [ptim_pkg::CNT_W-1:0] cnt;
      ptim_pkg::ptim_flags_s held;
      logic held_ht;
      logic uv_prev;
      logic tsd_prev;
      logic pg_oe;
      logic [2:0] ind_oe;
      logic pulse_en;
   } ptim_st_s;

   ptim_st_s st_ff;
   ptim_st_s nxt_st;
   logic [ptim_pkg::PCNT_W-1:0] on_cyc;

   assign on_cyc = duty_on(st_ff.held_ht, pulse_duty_select_i);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.uv_prev = uv_ok;
      nxt_st.tsd_prev = tsd;
      if (class_valid_i) begin
         nxt_st.held = encode_flags(class_i);
         nxt_st.held_ht = class_i.high_type_equipment;
      end
      unique case (st_ff.fsm)
         ptim_pkg::PTIM_ST_OFF: begin
            if (uv_ok && !tsd && (!st_ff.uv_prev || st_ff.tsd_prev)) begin
               nxt_st.fsm = ptim_pkg::PTIM_ST_INRUSH;
            end
         end
         ptim_pkg::PTIM_ST_INRUSH: begin
            if (inr_done) begin
               nxt_st.fsm = ptim_pkg::PTIM_ST_SETTLE;
               nxt_st.cnt = '0;
            end
         end
         ptim_pkg::PTIM_ST_SETTLE: begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            if (st_ff.cnt == ptim_pkg::CNT_W'(IND_DELAY - 1)) begin
               nxt_st.fsm = ptim_pkg::PTIM_ST_ON;
            end
         end
         ptim_pkg::PTIM_ST_ON: begin
         end
      endcase
      if (!uv_ok || tsd) begin
         nxt_st.fsm = ptim_pkg::PTIM_ST_OFF;
      end
      if (!mark_ok) begin
         nxt_st.held = ptim_pkg::FLAGS_RELEASED;
         nxt_st.held_ht = 1'b0;
      end
      nxt_st.pg_oe = (nxt_st.fsm == ptim_pkg::PTIM_ST_INRUSH);
      // Drive only flags that are low; kept state reapplied on re-entry
      nxt_st.ind_oe = (nxt_st.fsm == ptim_pkg::PTIM_ST_ON && v32_ok && !tsd) ?
                      ~nxt_st.held : 3'h0;
      nxt_st.pulse_en = (st_ff.fsm == ptim_pkg::PTIM_ST_ON) && ld_low;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '{fsm: ptim_pkg::PTIM_ST_OFF, cnt: '0, held: ptim_pkg::FLAGS_RELEASED,
                    held_ht: 1'b0, uv_prev: 1'b0, tsd_prev: 1'b0, pg_oe: 1'b0,
                    ind_oe: 3'h0, pulse_en: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   ptim_pulse_gen #(
      .PERIOD(PERIOD)
   ) u_pulse (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .enable_i(st_ff.pulse_en),
      .on_cycles_i(on_cyc),
      .pulse_o(signature_pulse_out_o)
   );

   assign power_good_out_o = 1'b0;
   assign power_good_out_oe_o = st_ff.pg_oe;
   assign flags_o = 3'h0;
   assign flags_oe_o = st_ff.ind_oe;
endmodule : ptim_indicator

// ---- ptim_indicator_properties.sv ----
`timescale 1ns/10ps
module ptim_indicator_properties (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic above_32v_i,
   input wire logic thermal_shutdown_i,
   input wire logic class_valid_i,
   input wire ptim_pkg::ptim_class_s class_i,
   input wire logic load_return_low_i,
   input wire logic power_good_out_o,
   input wire logic power_good_out_oe_o,
   input wire ptim_pkg::ptim_flags_s flags_o,
   input wire ptim_pkg::ptim_flags_s flags_oe_o,
   input wire logic signature_pulse_out_o
);
   // ****************
   // Checks
   // ****************
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   open_drain_low_a: assert property (!power_good_out_o && flags_o == 3'h0)
      else $error("open drain data not low");
   flags_after_inrush_a: assert property (flags_oe_o != 3'h0 |-> !power_good_out_oe_o)
      else $error("flags driven during inrush");
   inrush_flags_off_a: assert property ($rose(power_good_out_oe_o) |-> flags_oe_o == 3'h0)
      else $error("flags driven at inrush entry");
   thermal_release_a: assert property (thermal_shutdown_i [*6] |-> ##1 flags_oe_o == 3'h0)
      else $error("flags driven in thermal shutdown");
   low_supply_release_a: assert property (!above_32v_i [*6] |-> ##1 flags_oe_o == 3'h0)
      else $error("flags driven below supply level");
   pulse_stop_a: assert property (!load_return_low_i [*6] |-> ##2 !signature_pulse_out_o)
      else $error("pulse with high load current");
   pulse_not_inrush_a: assert property (signature_pulse_out_o |-> !power_good_out_oe_o)
      else $error("pulse during inrush");
   low_type_flag_a: assert property (class_valid_i && !class_i.high_type_equipment
      |=> ##1 !flags_oe_o.high_type_equipment_flag)
      else $error("type flag low for low type");
   five_events_a: assert property (class_valid_i && class_i == 4'hD
      && flags_oe_o.high_type_equipment_flag |=> ##1 flags_oe_o == 3'h7)
      else $error("five event code wrong");
endmodule : ptim_indicator_properties

bind ptim_indicator ptim_indicator_properties u_chk (.sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i), .above_32v_i(above_32v_i), .thermal_shutdown_i(thermal_shutdown_i),
   .class_valid_i(class_valid_i), .class_i(class_i), .load_return_low_i(load_return_low_i),
   .power_good_out_o(power_good_out_o), .power_good_out_oe_o(power_good_out_oe_o),
   .flags_o(flags_o), .flags_oe_o(flags_oe_o), .signature_pulse_out_o(signature_pulse_out_o));

// ---- ptim_pse_model.sv ----
`timescale 1ns/10ps
module ptim_pse_model (
   input wire logic sys_clk_i,
   input wire logic send_i,
   input wire ptim_pkg::ptim_class_s req_i,
   input wire logic pg_oe_i,
   input wire ptim_pkg::ptim_flags_s flags_oe_i,
   output logic class_valid_o,
   output ptim_pkg::ptim_class_s class_o,
   output logic pg_pin_o,
   output ptim_pkg::ptim_flags_s flags_pin_o
);
   initial begin
      class_valid_o = 1'b0;
      class_o = 4'h0;
   end
   // Idle class lines toggle so stale values are never trusted
   always @(posedge sys_clk_i) begin
      class_valid_o <= send_i;
      class_o <= send_i ? req_i : ~class_o;
   end
   // Pull-ups on the open-drain pins
   assign pg_pin_o = ~pg_oe_i;
   assign flags_pin_o = ~flags_oe_i;
endmodule : ptim_pse_model

// ---- ptim_indicator_tb.sv ----
`timescale 1ns/10ps
module ptim_indicator_tb;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic mr = 1'b1, uv = 1'b0, v32 = 1'b1, tsd = 1'b0, done = 1'b0, lrl = 1'b1, send = 1'b0;
   ptim_pkg::ptim_class_s req = 4'h0;
   ptim_pkg::ptim_class_s cls;
   ptim_pkg::ptim_duty_e duty = ptim_pkg::PTIM_DUTY_SHORT;
   logic cv, pg, pg_oe, pulse, pg_pin;
   ptim_pkg::ptim_flags_s fl, fl_oe, fl_pin;
   int fail_count = 0, n_tests = 0, cyc = 0, hi;
   logic [6:0] tab [7] = '{7'h0F, 7'h15, 7'h4E, 7'h54, 7'h5C, 7'h62, 7'h68};
   int pm [3] = '{ptim_pkg::DUTY_12P5_PM, ptim_pkg::DUTY_8P1_PM, ptim_pkg::DUTY_5P4_PM};
   always #25 sys_clk_i = ~sys_clk_i;
   ptim_indicator #(.IND_DELAY(20), .PERIOD(100)) dut (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .above_mark_reset_i(mr), .above_undervoltage_lockout_i(uv),
      .above_32v_i(v32), .thermal_shutdown_i(tsd), .inrush_done_i(done), .class_valid_i(cv),
      .class_i(cls), .pulse_duty_select_i(duty), .load_return_low_i(lrl),
      .power_good_out_o(pg), .power_good_out_oe_o(pg_oe), .flags_o(fl), .flags_oe_o(fl_oe),
      .signature_pulse_out_o(pulse));
   ptim_pse_model u_pse (.sys_clk_i(sys_clk_i), .send_i(send), .req_i(req), .pg_oe_i(pg_oe),
      .flags_oe_i(fl_oe), .class_valid_o(cv), .class_o(cls), .pg_pin_o(pg_pin),
      .flags_pin_o(fl_pin));
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("mismatches %0d checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : tick
   task automatic send_class(input logic [3:0] c);
      req = c;
      send = 1'b1;
      tick(1);
      send = 1'b0;
      tick(4);
   endtask : send_class
   task automatic count_pulses;
      hi = 0;
      repeat (100) begin
         tick(1);
         hi += (pulse === 1'b1);
      end
   endtask : count_pulses
   task automatic power_up;
      uv = 1'b1;
      hi = 0;
      while (pg_oe !== 1'b1 && hi < 20) begin
         tick(1);
         hi++;
      end
      check(pg_pin, 8'h00);
      check(fl_pin, 8'h07);
      done = 1'b1;
      tick(8);
      check(pg_pin, 8'h01);
      check(fl_pin, 8'h07);
      tick(30);
   endtask : power_up
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         complete_run();
      end
   end
   // ****************
   // Sequence
   // ****************
   initial begin
      repeat (6) @(posedge sys_clk_i);
      tick(1);
      sys_rst_i = 1'b0;
      power_up();
      check(fl_pin, 8'h07);
      for (int i = 0; i < 7; i++) begin
         send_class(tab[i][6:3]);
         check(fl_pin, 8'(tab[i][2:0]));
      end
      for (int d = 0; d < 3; d++) begin
         duty = ptim_pkg::ptim_duty_e'(d);
         tick(4);
         count_pulses();
         check(8'(hi), 8'(pm[d] * 100 / 1000));
      end
      send_class(4'h1);
      duty = ptim_pkg::PTIM_DUTY_SHORT;
      count_pulses();
      check(8'(hi), 8'(ptim_pkg::DUTY_26_PM * 100 / 1000));
      lrl = 1'b0;
      tick(8);
      count_pulses();
      check(8'(hi), 8'h00);
      send_class(4'hC);
      v32 = 1'b0;
      tick(8);
      check(fl_pin, 8'h07);
      v32 = 1'b1;
      tick(8);
      check(fl_pin, 8'h02);
      done = 1'b0;
      tsd = 1'b1;
      tick(8);
      check(fl_pin, 8'h07);
      tsd = 1'b0;
      power_up();
      check(fl_pin, 8'h02);
      mr = 1'b0;
      uv = 1'b0;
      done = 1'b0;
      tick(8);
      mr = 1'b1;
      tick(8);
      power_up();
      check(fl_pin, 8'h07);
      complete_run();
   end
endmodule : ptim_indicator_tb
